// File: rtl/alarm_defines.svh
// register offsets, field positions and reset values of the alarm register bank
`ifndef ALARM_DEFINES_SVH
`define ALARM_DEFINES_SVH

`define ADDR_W              12
`define DATA_W              8

`define OFS_ALARM_SUMMARY   12'h2C0
`define OFS_ALARM_FLAGS     12'h2C1
`define OFS_ALARM_MASK      12'h2C2
`define OFS_LANE_FLAGS_LO   12'h2C4
`define OFS_LANE_FLAGS_HI   12'h2C5

`define FLAG_COUNT          6
`define LANE_COUNT          16

`define BIT_DIVIDER_MISMATCH 0
`define BIT_UNUSED           1
`define BIT_CLOCK_REALIGN    2
`define BIT_LINK_STATE       3
`define BIT_LOCK_LOSS        4
`define BIT_LANE_FIFO        5

`define RST_ALARM_SUMMARY   8'h00
`define RST_ALARM_FLAGS     6'h3F
`define RST_ALARM_MASK      8'h3F
`define RST_LANE_FLAGS      16'hFFFF
`define RST_READ_DATA       8'h00

`endif

// File: rtl/alarm_pkg.sv
// types shared by the alarm register bank
package alarm_pkg;
    typedef logic [11:0] reg_addr_t;
    typedef logic [7:0]  reg_byte_t;
    typedef logic [5:0]  alarm_vec_t;
    typedef logic [15:0] lane_vec_t;
endpackage

// File: rtl/flag_if.sv
// carrier between the register bank and a bank of sticky flags
`timescale 1ns/1ps
`default_nettype none
interface flag_if #(parameter int W = 8);
    logic [W-1:0] set_bits;
    logic [W-1:0] clear_bits;
    logic         load_ones;
    logic [W-1:0] flags;
    modport bank (input set_bits, input clear_bits, input load_ones, output flags);
    modport user (output set_bits, output clear_bits, output load_ones, input flags);
endinterface
`default_nettype wire

// File: rtl/sticky_flags.sv
// bank of sticky write-one-to-clear flags that reset to one
`timescale 1ns/1ps
`default_nettype none
module sticky_flags #(
    parameter int W = 8
) (
    input  wire logic ref_clk_in,
    input  wire logic reset_in,
    input  wire logic ce_in,
    flag_if.bank      port
);
    logic [W-1:0] flags_reg;
    logic [W-1:0] flags_next;

    // set beats clear so an event in the clearing cycle is kept
    always_comb begin
        flags_next = flags_reg;
        if (port.load_ones) begin
            flags_next = {W{1'b1}};
        end else begin
            flags_next = (flags_reg & ~port.clear_bits) | port.set_bits;
        end
    end

    always_ff @(posedge ref_clk_in or posedge reset_in) begin
        if (reset_in) begin
            flags_reg <= {W{1'b1}};
        end else if (ce_in) begin
            flags_reg <= flags_next;
        end
    end

    assign port.flags = flags_reg;
endmodule
`default_nettype wire

// File: rtl/alarm_status_aggregator.sv
// alarm flags, mask, summary bit and status pin routing
`timescale 1ns/1ps
`default_nettype none
`include "alarm_defines.svh"

// How it works
// [RULE_01] summary bit is one when any unmasked flag is set, else zero
// [RULE_02] status pin select routes summary bit onto the status output pin
// [RULE_03] one mask bit per flag; masked flags ignored; masks reset set
// [RULE_04] bit 5 sets when any active lane fifo overflows or underflows
// [RULE_05] sixteen per-lane fifo flags, each set by its lane, write one clears
// [RULE_06] software reads per-lane flags to find the failing lanes
// [RULE_07] writing one to bit 5 also clears all per-lane flags
// [RULE_08] bit 4 sets whenever the pll is not locked
// [RULE_09] 8b/10b: bit 3 sets while link enabled but not in data state
// [RULE_10] 64b/66b: bit 3 sets at link start and on any realignment
// [RULE_11] bit 2 sets when sysref realigns the internal clocks
// [RULE_12] bit 0 sets when channel a and b dividers disagree
// [RULE_13] writing one to a flag bit clears that flag
// [RULE_14] power-on or soft reset loads one into every flag
// [RULE_15] with link disabled only the divider flag is meaningful
// [RULE_16] software should clear all flags after enabling the link
// [RULE_17] writing zero keeps a flag; a persisting condition sets it again
// [RULE_18] summary drops once all unmasked flags are cleared or masked
module alarm_status_aggregator
    import alarm_pkg::*;
#(
    parameter int LANES = `LANE_COUNT,
    parameter int DIV_W = 4
) (
    input  wire logic                  ref_clk_in,
    input  wire logic                  reset_in,
    input  wire logic                  ce_in,
    input  wire logic                  soft_reset_in,
    input  wire alarm_pkg::reg_addr_t  reg_addr_in,
    input  wire logic                  reg_wr_in,
    input  wire logic                  reg_rd_in,
    input  wire alarm_pkg::reg_byte_t  reg_wdata_in,
    output logic [7:0]                 reg_rdata_out,
    input  wire logic [LANES-1:0]      lane_fifo_error_in,
    input  wire logic [LANES-1:0]      lane_active_in,
    input  wire logic                  pll_locked_in,
    input  wire logic                  serial_link_enable_in,
    input  wire logic                  encoding_64b66b_in,
    input  wire logic                  link_in_data_state_in,
    input  wire logic                  link_startup_in,
    input  wire logic                  link_realign_in,
    input  wire logic                  clock_realign_in,
    input  wire logic [DIV_W-1:0]      divider_a_in,
    input  wire logic [DIV_W-1:0]      divider_b_in,
    input  wire logic                  status_pin_select_in,
    input  wire logic                  calibration_status_in,
    output logic                       alarm_summary_out,
    output logic                       status_output_pin_out
);
    import alarm_pkg::*;

    flag_if #(.W(`FLAG_COUNT)) alarm_port ();
    flag_if #(.W(LANES))       lane_port ();

    logic [7:0]       alarm_mask_bits_reg;
    logic [7:0]       alarm_mask_bits_next;
    logic             summary_reg;
    logic             summary_next;
    logic             status_pin_reg;
    logic             status_pin_next;
    logic [7:0]       rdata_reg;
    logic [7:0]       rdata_next;

    logic             wr_flags;
    logic             wr_mask;
    logic             wr_lane_lo;
    logic             wr_lane_hi;
    logic [`FLAG_COUNT-1:0] alarm_flags;
    logic [LANES-1:0] per_lane_fifo_flags;
    logic [`FLAG_COUNT-1:0] alarm_set;
    logic [`FLAG_COUNT-1:0] alarm_clear;
    logic [LANES-1:0] lane_set;
    logic [LANES-1:0] lane_clear;
    logic             lane_fifo_error_flag;
    logic             lock_loss_flag;
    logic             link_state_flag;
    logic             clock_realign_flag;
    logic             divider_mismatch_flag;
    logic             unmasked_any;
    logic             rd_summary;
    logic             rd_flags;
    logic             rd_mask;
    logic             rd_lane_lo;
    logic             rd_lane_hi;
    logic             link_alarm_8b10b;
    logic             link_alarm_64b66b;
    logic [LANES-1:0] lane_hits;
    logic [7:0]       lane_lo_byte;
    logic [7:0]       lane_hi_byte;
    logic [`FLAG_COUNT-1:0] masked_flags;

    sticky_flags #(.W(`FLAG_COUNT)) alarm_bank (
        .ref_clk_in (ref_clk_in),
        .reset_in   (reset_in),
        .ce_in      (ce_in),
        .port       (alarm_port.bank)
    );

    sticky_flags #(.W(LANES)) lane_bank (
        .ref_clk_in (ref_clk_in),
        .reset_in   (reset_in),
        .ce_in      (ce_in),
        .port       (lane_port.bank)
    );

    assign alarm_flags         = alarm_port.flags;
    assign per_lane_fifo_flags = lane_port.flags;

    // address decode of the register port; writes to the read-only summary vanish
    always_comb begin
        wr_flags   = 1'b0;
        wr_mask    = 1'b0;
        wr_lane_lo = 1'b0;
        wr_lane_hi = 1'b0;
        if (reg_wr_in) begin
            case (reg_addr_in)
                `OFS_ALARM_FLAGS:   wr_flags   = 1'b1;
                `OFS_ALARM_MASK:    wr_mask    = 1'b1;
                `OFS_LANE_FLAGS_LO: wr_lane_lo = 1'b1;
                `OFS_LANE_FLAGS_HI: wr_lane_hi = 1'b1;
                default:            wr_flags   = 1'b0;
            endcase
        end
    end

    always_comb begin
        rd_summary = 1'b0;
        rd_flags   = 1'b0;
        rd_mask    = 1'b0;
        rd_lane_lo = 1'b0;
        rd_lane_hi = 1'b0;
        if (reg_rd_in) begin
            case (reg_addr_in)
                `OFS_ALARM_SUMMARY: rd_summary = 1'b1;
                `OFS_ALARM_FLAGS:   rd_flags   = 1'b1;
                `OFS_ALARM_MASK:    rd_mask    = 1'b1;
                `OFS_LANE_FLAGS_LO: rd_lane_lo = 1'b1;
                `OFS_LANE_FLAGS_HI: rd_lane_hi = 1'b1;
                default:            rd_summary = 1'b0;
            endcase
        end
    end

    // inactive lanes never raise an alarm, neither summed nor per lane
    always_comb begin
        lane_hits = lane_fifo_error_in & lane_active_in; // [RULE_04] [RULE_05]
    end

    always_comb begin
        link_alarm_8b10b  = serial_link_enable_in && !link_in_data_state_in; // [RULE_09]
        link_alarm_64b66b = serial_link_enable_in
                            && (link_startup_in || link_realign_in); // [RULE_10]
    end

    // alarm conditions; apart from the link-state flag, which is gated by the link enable,
    // the flags are not gated while the link is off; downstream logic must not trust them then
    always_comb begin
        lane_fifo_error_flag  = |lane_hits; // [RULE_04]
        lock_loss_flag        = !pll_locked_in; // [RULE_08]
        if (encoding_64b66b_in) begin
            link_state_flag = link_alarm_64b66b; // [RULE_10]
        end else begin
            link_state_flag = link_alarm_8b10b; // [RULE_09]
        end
        clock_realign_flag    = clock_realign_in; // [RULE_11]
        // the one flag that stays meaningful with the link off
        divider_mismatch_flag = (divider_a_in != divider_b_in); // [RULE_12] [RULE_15]
    end

    // set and clear vectors for the status flags
    always_comb begin
        alarm_set = '0;
        alarm_set[`BIT_LANE_FIFO]        = lane_fifo_error_flag;
        alarm_set[`BIT_LOCK_LOSS]        = lock_loss_flag;
        alarm_set[`BIT_LINK_STATE]       = link_state_flag;
        alarm_set[`BIT_CLOCK_REALIGN]    = clock_realign_flag;
        alarm_set[`BIT_DIVIDER_MISMATCH] = divider_mismatch_flag;
        // zeros in the write data leave flags alone
        alarm_clear = wr_flags ? reg_wdata_in[`FLAG_COUNT-1:0] : '0; // [RULE_13] [RULE_17]
    end

    // per-lane flags, cleared per byte or all at once through bit 5
    always_comb begin
        lane_set   = lane_hits; // [RULE_05]
        lane_clear = '0;
        if (wr_lane_lo) begin
            lane_clear[7:0] = reg_wdata_in; // [RULE_05]
        end
        if (wr_lane_hi) begin
            lane_clear[LANES-1:8] = reg_wdata_in[LANES-9:0];
        end
        if (wr_flags && reg_wdata_in[`BIT_LANE_FIFO]) begin
            lane_clear = '1; // [RULE_07]
        end
    end

    always_comb begin
        alarm_port.set_bits   = alarm_set;
        alarm_port.clear_bits = alarm_clear;
        alarm_port.load_ones  = soft_reset_in; // [RULE_14]
        lane_port.set_bits    = lane_set;
        lane_port.clear_bits  = lane_clear;
        lane_port.load_ones   = soft_reset_in; // [RULE_14]
    end

    // mask register; reserved bits kept as plain storage
    always_comb begin
        alarm_mask_bits_next = alarm_mask_bits_reg;
        if (soft_reset_in) begin
            alarm_mask_bits_next = `RST_ALARM_MASK; // [RULE_03]
        end else if (wr_mask) begin
            alarm_mask_bits_next = reg_wdata_in;
        end
    end

    // summary, and the pin when status_pin_select_in is set, follow the flags one cycle later, no acknowledge needed
    always_comb begin
        masked_flags    = alarm_flags & ~alarm_mask_bits_reg[`FLAG_COUNT-1:0]; // [RULE_03]
        unmasked_any    = |masked_flags;
        summary_next    = unmasked_any; // [RULE_01] [RULE_18]
        status_pin_next = status_pin_select_in ? unmasked_any
                                               : calibration_status_in; // [RULE_02]
    end

    always_comb begin
        lane_lo_byte = per_lane_fifo_flags[7:0];
        lane_hi_byte = per_lane_fifo_flags[LANES-1:8];
    end

    // read path: data is valid the cycle after the read strobe and held
    always_comb begin
        rdata_next = rdata_reg;
        if (rd_summary) begin
            rdata_next = {7'h00, summary_reg}; // [RULE_01]
        end else if (rd_flags) begin
            rdata_next = {2'h0, alarm_flags};
        end else if (rd_mask) begin
            rdata_next = alarm_mask_bits_reg;
        end else if (rd_lane_lo) begin
            rdata_next = lane_lo_byte; // [RULE_06]
        end else if (rd_lane_hi) begin
            rdata_next = lane_hi_byte; // [RULE_06]
        end else if (reg_rd_in) begin
            // holes read as zero so software can probe safely
            rdata_next = `RST_READ_DATA;
        end
    end

    always_ff @(posedge ref_clk_in or posedge reset_in) begin
        if (reset_in) begin
            alarm_mask_bits_reg <= `RST_ALARM_MASK; // [RULE_03]
        end else if (ce_in) begin
            alarm_mask_bits_reg <= alarm_mask_bits_next;
        end
    end

    // summary lags the flags by one cycle; the price of a clean flop output
    always_ff @(posedge ref_clk_in or posedge reset_in) begin
        if (reset_in) begin
            summary_reg <= 1'b0;
        end else if (ce_in) begin
            summary_reg <= summary_next;
        end
    end

    // pin is a flop so it never glitches while flags settle
    always_ff @(posedge ref_clk_in or posedge reset_in) begin
        if (reset_in) begin
            status_pin_reg <= 1'b0;
        end else if (ce_in) begin
            status_pin_reg <= status_pin_next;
        end
    end

    always_ff @(posedge ref_clk_in or posedge reset_in) begin
        if (reset_in) begin
            rdata_reg <= `RST_READ_DATA;
        end else if (ce_in) begin
            rdata_reg <= rdata_next;
        end
    end

    assign reg_rdata_out         = rdata_reg;
    assign alarm_summary_out     = summary_reg;
    assign status_output_pin_out = status_pin_reg;
endmodule
`default_nettype wire

// File: verification/alarm_chk.sv
// port-level assertions for the alarm register bank
`timescale 1ns/1ps
`default_nettype none
module alarm_chk
    import alarm_pkg::*;
(
    input wire logic                 ref_clk_in,
    input wire logic                 reset_in,
    input wire logic                 ce_in,
    input wire logic                 soft_reset_in,
    input wire alarm_pkg::reg_addr_t reg_addr_in,
    input wire logic                 reg_wr_in,
    input wire logic                 reg_rd_in,
    input wire alarm_pkg::reg_byte_t reg_wdata_in,
    input wire logic [7:0]           reg_rdata_out,
    input wire logic                 pll_locked_in,
    input wire logic                 status_pin_select_in,
    input wire logic                 calibration_status_in,
    input wire logic                 alarm_summary_out,
    input wire logic                 status_output_pin_out
);
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (reset_in);
    // shadow of the mask, so summary checks know which flags count
    logic [7:0] mask_reg;
    logic [7:0] mask_next;
    always_comb begin
        mask_next = mask_reg;
        if (ce_in && soft_reset_in)
            mask_next = 8'h3F;
        else if (ce_in && reg_wr_in && reg_addr_in == 12'h2C2)
            mask_next = reg_wdata_in;
    end
    always_ff @(posedge ref_clk_in or posedge reset_in) begin
        if (reset_in)
            mask_reg <= 8'h3F;
        else
            mask_reg <= mask_next;
    end
    a_pin_follows_sum:
        assert property (ce_in && status_pin_select_in |=>
            status_output_pin_out == alarm_summary_out) else $error("pin not summary");
    a_pin_shows_cal:
        assert property (ce_in && !status_pin_select_in |=>
            status_output_pin_out == $past(calibration_status_in)) else $error("pin not cal");
    a_lock_loss_alarm:
        assert property ((ce_in && !pll_locked_in && !mask_reg[4] && !reg_wr_in && !soft_reset_in)
            ##1 (ce_in && !reg_wr_in) |=> alarm_summary_out) else $error("lock loss missed");
    a_all_masked_quiet:
        assert property (ce_in && mask_reg[5:0] == 6'h3F |=> !alarm_summary_out)
            else $error("masked summary high");
    a_rdata_holds:
        assert property (!(ce_in && reg_rd_in) |=> $stable(reg_rdata_out))
            else $error("read data moved");
    a_frozen_outputs:
        assert property (!ce_in |=> $stable(alarm_summary_out) && $stable(status_output_pin_out))
            else $error("outputs moved while frozen");
    a_unmapped_zero:
        assert property (ce_in && reg_rd_in && reg_addr_in == 12'h2C3 |=> reg_rdata_out == 8'h00)
            else $error("unmapped read not zero");
    a_flags_top_zero:
        assert property (ce_in && reg_rd_in && reg_addr_in == 12'h2C1 |=>
            reg_rdata_out[7:6] == 2'b00) else $error("flag top bits set");
    a_summary_byte:
        assert property (ce_in && reg_rd_in && reg_addr_in == 12'h2C0 |=>
            reg_rdata_out[7:1] == 7'h00) else $error("summary upper bits set");
    a_soft_reset_ones:
        assert property ((ce_in && soft_reset_in) ##1 (ce_in && !reg_wr_in) ##1
            (ce_in && reg_rd_in && reg_addr_in == 12'h2C1) |=> reg_rdata_out == 8'h3F)
            else $error("soft reset flags wrong");
    a_mask_readback:
        assert property (ce_in && reg_rd_in && reg_addr_in == 12'h2C2 |=>
            reg_rdata_out == $past(mask_reg)) else $error("mask read wrong");
endmodule
bind alarm_status_aggregator alarm_chk u_chk (.ref_clk_in, .reset_in, .ce_in, .soft_reset_in,
    .reg_addr_in, .reg_wr_in, .reg_rd_in, .reg_wdata_in, .reg_rdata_out, .pll_locked_in,
    .status_pin_select_in, .calibration_status_in, .alarm_summary_out, .status_output_pin_out);
`default_nettype wire

// File: verification/alarm_status_aggregator_test.sv
// self-checking bench for the alarm register bank
`timescale 1ns/1ps
`default_nettype none
module alarm_status_aggregator_test;
    import alarm_pkg::*;
    logic        ref_clk_in, reset_in, ce_in, soft_reset_in, reg_wr_in, reg_rd_in;
    reg_addr_t   reg_addr_in;
    reg_byte_t   reg_wdata_in;
    logic [7:0]  reg_rdata_out;
    logic [15:0] lane_fifo_error_in, lane_active_in;
    logic        pll_locked_in, serial_link_enable_in, encoding_64b66b_in;
    logic        link_in_data_state_in, link_startup_in, link_realign_in, clock_realign_in;
    logic [3:0]  divider_a_in, divider_b_in;
    logic        status_pin_select_in, calibration_status_in;
    logic        alarm_summary_out, status_output_pin_out;
    int          bad_count = 0;
    int          checked = 0;
    int          cycles = 0;
    localparam reg_byte_t exp_flags [9] = '{8'h01, 8'h10, 8'h04, 8'h08, 8'h08, 8'h08, 8'h20,
                                            8'h00, 8'h00};
    alarm_status_aggregator DUT (.ref_clk_in, .reset_in, .ce_in, .soft_reset_in, .reg_addr_in,
        .reg_wr_in, .reg_rd_in, .reg_wdata_in, .reg_rdata_out, .lane_fifo_error_in,
        .lane_active_in, .pll_locked_in, .serial_link_enable_in, .encoding_64b66b_in,
        .link_in_data_state_in, .link_startup_in, .link_realign_in, .clock_realign_in,
        .divider_a_in, .divider_b_in, .status_pin_select_in, .calibration_status_in,
        .alarm_summary_out, .status_output_pin_out);
    initial begin
        ref_clk_in = 1'b0;
        forever #5 ref_clk_in = ~ref_clk_in;
    end
    task automatic close_out;
        if (bad_count == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // cuts a hang short; a full run needs about 130 cycles
    always @(posedge ref_clk_in) begin
        cycles++;
        if (cycles == 5000) begin
            bad_count++;
            close_out();
        end
    end
    task automatic chk(input reg_byte_t got, input reg_byte_t exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic step;
        @(posedge ref_clk_in);
        #1;
    endtask
    task automatic wr(input reg_addr_t a, input reg_byte_t d);
        step();
        reg_addr_in = a;
        reg_wdata_in = d;
        reg_wr_in = 1'b1;
        step();
        reg_wr_in = 1'b0;
    endtask
    task automatic rd(input reg_addr_t a, input reg_byte_t exp);
        step();
        reg_addr_in = a;
        reg_rd_in = 1'b1;
        step();
        reg_rd_in = 1'b0;
        chk(reg_rdata_out, exp);
    endtask
    // quiet conditions: sticky flags then only change by software
    task automatic idle;
        pll_locked_in = 1'b1;
        {serial_link_enable_in, encoding_64b66b_in, link_in_data_state_in} = 3'b000;
        {link_startup_in, link_realign_in, clock_realign_in} = 3'b000;
        divider_b_in = divider_a_in;
        lane_fifo_error_in = 16'h0000;
    endtask
    task automatic pulse(input int k);
        step();
        case (k)
            0: divider_b_in = 4'hA;
            1: pll_locked_in = 1'b0;
            2: clock_realign_in = 1'b1;
            3: serial_link_enable_in = 1'b1;
            4: {serial_link_enable_in, encoding_64b66b_in, link_startup_in} = 3'b111;
            5: {serial_link_enable_in, encoding_64b66b_in, link_realign_in} = 3'b111;
            6: lane_fifo_error_in = 16'h0200;
            7: lane_fifo_error_in = 16'h0008;
            default: {serial_link_enable_in, link_in_data_state_in} = 2'b11;
        endcase
        step();
        idle();
    endtask
    task automatic test_reset;
        rd(12'h2C1, 8'h3F);
        rd(12'h2C2, 8'h3F);
        rd(12'h2C4, 8'hFF);
        rd(12'h2C5, 8'hFF);
        rd(12'h2C0, 8'h00);
        rd(12'h2C3, 8'h00);
    endtask
    task automatic test_clear;
        wr(12'h2C1, 8'h00);
        rd(12'h2C1, 8'h3F);
        wr(12'h2C1, 8'h3F);
        rd(12'h2C1, 8'h00);
        rd(12'h2C4, 8'h00);
        rd(12'h2C5, 8'h00);
        soft_reset_in = 1'b1;
        step();
        soft_reset_in = 1'b0;
        rd(12'h2C1, 8'h3F);
        rd(12'h2C5, 8'hFF);
        wr(12'h2C5, 8'h81);
        rd(12'h2C5, 8'h7E);
        rd(12'h2C4, 8'hFF);
        wr(12'h2C4, 8'h0F);
        rd(12'h2C4, 8'hF0);
        rd(12'h2C1, 8'h3F);
        wr(12'h2C1, 8'h3F);
    endtask
    task automatic test_sources;
        for (int k = 0; k < 9; k++) begin
            pulse(k);
            rd(12'h2C1, exp_flags[k]);
            if (k == 6)
                rd(12'h2C5, 8'h02);
            if (k == 7)
                rd(12'h2C4, 8'h00);
            wr(12'h2C1, 8'h3F);
        end
    endtask
    task automatic test_summary;
        calibration_status_in = 1'b0;
        wr(12'h2C2, 8'h00);
        pulse(2);
        step();
        chk({7'h00, alarm_summary_out}, 8'h01);
        chk({7'h00, status_output_pin_out}, 8'h01);
        rd(12'h2C0, 8'h01);
        wr(12'h2C2, 8'h04);
        step();
        chk({7'h00, alarm_summary_out}, 8'h00);
        chk({7'h00, status_output_pin_out}, 8'h00);
        wr(12'h2C2, 8'h00);
        wr(12'h2C1, 8'h04);
        step();
        chk({7'h00, alarm_summary_out}, 8'h00);
        {status_pin_select_in, calibration_status_in} = 2'b01;
        step();
        chk({7'h00, status_output_pin_out}, 8'h01);
    endtask
    task automatic test_persist;
        pll_locked_in = 1'b0;
        step();
        wr(12'h2C1, 8'h10);
        rd(12'h2C1, 8'h10);
        idle();
        wr(12'h2C1, 8'h10);
        rd(12'h2C1, 8'h00);
        ce_in = 1'b0;
        pulse(2);
        ce_in = 1'b1;
        rd(12'h2C1, 8'h00);
    endtask
    initial begin
        {reset_in, ce_in, soft_reset_in, reg_wr_in, reg_rd_in} = 5'b11000;
        reg_addr_in = 12'h000;
        reg_wdata_in = 8'h00;
        divider_a_in = 4'h5;
        lane_active_in = 16'hFFF7;
        {status_pin_select_in, calibration_status_in} = 2'b11;
        idle();
        repeat (3) @(posedge ref_clk_in);
        #1;
        reset_in = 1'b0;
        test_reset();
        test_clear();
        test_sources();
        test_summary();
        test_persist();
        close_out();
    end
endmodule
`default_nettype wire
